//--- src/sbcc_pkg.sv
// constants and types for the secondary bus command control block
package sbcc_pkg;

    // configuration dword holding the command half and the status half
    localparam logic [11:0] SBCC_CMD_OFFSET     = 12'h044;
    localparam logic [15:0] SBCC_CMD_RESET      = 16'h0000;
    localparam logic [15:0] SBCC_CMD_WR_MASK    = 16'h0547;

    // command field positions
    localparam int SBCC_IO_EN_BIT      = 0;
    localparam int SBCC_MEM_EN_BIT     = 1;
    localparam int SBCC_BUS_MASTER_BIT = 2;
    localparam int SBCC_SPEC_CYC_BIT   = 3;
    localparam int SBCC_MWI_EN_BIT     = 4;
    localparam int SBCC_PAL_SNOOP_BIT  = 5;
    localparam int SBCC_PAR_RESP_BIT   = 6;
    localparam int SBCC_WAIT_CYC_BIT   = 7;
    localparam int SBCC_SERR_EN_BIT    = 8;
    localparam int SBCC_FAST_B2B_BIT   = 9;
    localparam int SBCC_INT_DIS_BIT    = 10;

    // status half: master data parity error flag, write one to clear
    localparam int   SBCC_MDPE_BIT     = 24;
    localparam logic SBCC_MDPE_RESET   = 1'b0;

    // configuration access request
    typedef struct packed {
        logic        req;
        logic        we;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } sbcc_cfg_req_t;

    // configuration read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } sbcc_cfg_rsp_t;

    // secondary-side gates driven by the command half
    typedef struct packed {
        logic io_respond;
        logic mem_rd_respond;
        logic master_en;
        logic split_cpl_en;
        logic special_cyc_respond;
        logic mwi_originate;
        logic palette_snoop;
        logic err_msg_send;
        logic serr_drive;
        logic intx_assert;
    } sbcc_gate_t;

endpackage : sbcc_pkg

//--- src/sbcc_cmd.sv
// secondary bus command register with its gating of secondary-side behaviour
//
// Behaviour
// - io decode clear blocks secondary io response
// - memory enable gates secondary memory reads
// - bus master clear stops io and memory initiate and respond; mwi origination is not gated by it
// - reverse pci-x may always issue split completions
// - special cycle bit zero, never respond
// - mwi bit zero, only forwarded mwi
// - palette snoop bit zero, snoops ignored
// - parity enable gates master parity flag
// - wait cycle control reads zero
// - serr enable gates error messages or serr
// - fast back-to-back bit reads zero
// - interrupt disable blocks and releases intx
// - parity flag is write-one-to-clear, enable qualified
`timescale 1ns/100ps
`default_nettype none

module sbcc_cmd (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire sbcc_pkg::sbcc_cfg_req_t cfg_req,
    output var  sbcc_pkg::sbcc_cfg_rsp_t cfg_rsp,
    input  wire logic                   reverse_mode,
    input  wire logic                   pcix_mode,
    input  wire logic                   fwd_mwi_req,
    input  wire logic                   parity_event,
    input  wire logic                   err_event,
    input  wire logic                   intx_pending,
    output var  sbcc_pkg::sbcc_gate_t    gate
);
    import sbcc_pkg::*;

    // register state
    logic        io_en_q;
    logic        mem_en_q;
    logic        bme_q;
    logic        par_resp_q;
    logic        serr_en_q;
    logic        int_dis_q;
    logic        mdpe_q;
    logic        mdpe_d;

    // request decode
    logic        hit;
    logic        rd_hit;
    logic        wr_lo;
    logic        wr_hi;
    logic        clr_mdpe;
    logic        set_mdpe;
    logic        rev_pcix;
    logic [15:0] wdata_lo;
    logic [31:0] rd_word;

    // read answer flops
    logic        rsp_valid_q;
    logic [31:0] rsp_data_q;

    // one flop per secondary-side gate
    logic        io_resp_q;
    logic        mem_rd_q;
    logic        master_q;
    logic        split_q;
    logic        spec_cyc_q;
    logic        mwi_q;
    logic        snoop_q;
    logic        err_msg_q;
    logic        serr_q;
    logic        intx_q;

    assign hit      = cfg_req.req && (cfg_req.addr == SBCC_CMD_OFFSET);
    assign rd_hit   = hit && !cfg_req.we;
    assign wdata_lo = cfg_req.wdata[15:0];
    assign wr_lo    = hit && cfg_req.we && cfg_req.be[0];
    assign wr_hi    = hit && cfg_req.we && cfg_req.be[1];
    assign clr_mdpe = hit && cfg_req.we && cfg_req.be[3]
                      && cfg_req.wdata[SBCC_MDPE_BIT];

    assign rev_pcix = reverse_mode && pcix_mode;
    // parity condition only counts while its response enable is on
    assign set_mdpe = parity_event && par_resp_q;

    // each enable has its own flop; read-only bits have no storage,
    // so no write can ever make them read back as one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_en_q <= SBCC_CMD_RESET[SBCC_IO_EN_BIT];
        end else if (wr_lo) begin
            io_en_q <= wdata_lo[SBCC_IO_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_en_q <= SBCC_CMD_RESET[SBCC_MEM_EN_BIT];
        end else if (wr_lo) begin
            mem_en_q <= wdata_lo[SBCC_MEM_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bme_q <= SBCC_CMD_RESET[SBCC_BUS_MASTER_BIT];
        end else if (wr_lo) begin
            bme_q <= wdata_lo[SBCC_BUS_MASTER_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_resp_q <= SBCC_CMD_RESET[SBCC_PAR_RESP_BIT];
        end else if (wr_lo) begin
            par_resp_q <= wdata_lo[SBCC_PAR_RESP_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serr_en_q <= SBCC_CMD_RESET[SBCC_SERR_EN_BIT];
        end else if (wr_hi) begin
            serr_en_q <= wdata_lo[SBCC_SERR_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_dis_q <= SBCC_CMD_RESET[SBCC_INT_DIS_BIT];
        end else if (wr_hi) begin
            int_dis_q <= wdata_lo[SBCC_INT_DIS_BIT];
        end
    end

    // set wins over a clear landing in the same cycle, so an error that
    // races the software clear is never lost
    always_comb begin
        mdpe_d = mdpe_q;
        if (set_mdpe) begin
            mdpe_d = 1'b1;
        end else if (clr_mdpe) begin
            mdpe_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdpe_q <= SBCC_MDPE_RESET;
        end else begin
            mdpe_q <= mdpe_d;
        end
    end

    // read word: implemented bits placed by name, everything else zero;
    // the status half carries only the parity flag
    always_comb begin
        rd_word                      = '0;
        rd_word[SBCC_IO_EN_BIT]      = io_en_q;
        rd_word[SBCC_MEM_EN_BIT]     = mem_en_q;
        rd_word[SBCC_BUS_MASTER_BIT] = bme_q;
        rd_word[SBCC_SPEC_CYC_BIT]   = 1'b0;
        rd_word[SBCC_MWI_EN_BIT]     = 1'b0;
        rd_word[SBCC_PAL_SNOOP_BIT]  = 1'b0;
        rd_word[SBCC_PAR_RESP_BIT]   = par_resp_q;
        rd_word[SBCC_WAIT_CYC_BIT]   = 1'b0;
        rd_word[SBCC_SERR_EN_BIT]    = serr_en_q;
        rd_word[SBCC_FAST_B2B_BIT]   = 1'b0;
        rd_word[SBCC_INT_DIS_BIT]    = int_dis_q;
        rd_word[SBCC_MDPE_BIT]       = mdpe_q;
    end

    // read answer one cycle after the request; unmapped offsets read zero
    // but are still answered, so software never waits on a hole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= cfg_req.req && !cfg_req.we;
        end
    end

    // data held at zero outside its cycle so a stale word never leaks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_data_q <= '0;
        end else if (rd_hit) begin
            rsp_data_q <= rd_word;
        end else begin
            rsp_data_q <= '0;
        end
    end

    assign cfg_rsp = '{valid: rsp_valid_q, rdata: rsp_data_q};

    // io response needs both its decode enable and bus mastering
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_resp_q <= 1'b0;
        end else begin
            io_resp_q <= io_en_q && bme_q;
        end
    end

    // memory reads pair their enable with bus mastering the same way
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_q <= 1'b0;
        end else begin
            mem_rd_q <= mem_en_q && bme_q;
        end
    end

    // forwarding memory and io as a master on the secondary side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_q <= 1'b0;
        end else begin
            master_q <= bme_q;
        end
    end

    // a reverse bridge on pci-x may return split completions even while
    // bus mastering is off, or its requesters would wait forever
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            split_q <= 1'b0;
        end else begin
            split_q <= bme_q || rev_pcix;
        end
    end

    // special cycles are never claimed as a target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_cyc_q <= 1'b0;
        end else begin
            spec_cyc_q <= 1'b0;
        end
    end

    // only a forwarded mwi may go out, and never in pci-x mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mwi_q <= 1'b0;
        end else begin
            mwi_q <= fwd_mwi_req && !pcix_mode;
        end
    end

    // palette snoops on the secondary side are ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snoop_q <= 1'b0;
        end else begin
            snoop_q <= 1'b0;
        end
    end

    // forward mode reports errors upstream as messages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_msg_q <= 1'b0;
        end else begin
            err_msg_q <= err_event && !reverse_mode
                         && serr_en_q;
        end
    end

    // reverse mode signals errors on the secondary error pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serr_q <= 1'b0;
        end else begin
            serr_q <= err_event && reverse_mode
                      && serr_en_q;
        end
    end

    // setting the disable drops an already asserted line next edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intx_q <= 1'b0;
        end else begin
            intx_q <= intx_pending && !int_dis_q;
        end
    end

    // the gate bundle is pure wiring of the flops above
    assign gate = '{
        io_respond:          io_resp_q,
        mem_rd_respond:      mem_rd_q,
        master_en:           master_q,
        split_cpl_en:        split_q,
        special_cyc_respond: spec_cyc_q,
        mwi_originate:       mwi_q,
        palette_snoop:       snoop_q,
        err_msg_send:        err_msg_q,
        serr_drive:          serr_q,
        intx_assert:         intx_q
    };

endmodule : sbcc_cmd

`default_nettype wire

//--- verif/sbcc_far_model.sv
// behavioural secondary-side agents: modes, errors, interrupt requests
`timescale 1ns/100ps
`default_nettype none
module sbcc_far_model (
    input  wire logic clk,
    output logic      rev,
    output logic      pcx,
    output logic      mwi,
    output logic      err,
    output logic      intx
);
    // fresh conditions each cycle so every gate fed by them sees both polarities
    initial {rev, pcx, mwi, err, intx} = '0;
    always @(posedge clk) #1 {rev, pcx, mwi, err, intx} = 5'($urandom);
endmodule : sbcc_far_model
`default_nettype wire

//--- verif/sbcc_cmd_properties.sv
// port assertions for the secondary bus command register
`timescale 1ns/100ps
`default_nettype none
module sbcc_cmd_properties import sbcc_pkg::*; (
    input wire logic clk, input wire logic rst_n,
    input wire sbcc_cfg_req_t cfg_req, input wire sbcc_cfg_rsp_t cfg_rsp,
    input wire logic reverse_mode, input wire logic pcix_mode,
    input wire logic fwd_mwi_req, input wire logic parity_event,
    input wire logic err_event, input wire logic intx_pending,
    input wire sbcc_gate_t gate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // writable enables as software last wrote them, tracked from the port
    logic [15:0] shadow_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_q <= SBCC_CMD_RESET;
        end else if (cfg_req.req && cfg_req.we
                     && cfg_req.addr == SBCC_CMD_OFFSET) begin
            if (cfg_req.be[0]) shadow_q[7:0] <= cfg_req.wdata[7:0];
            if (cfg_req.be[1]) shadow_q[15:8] <= cfg_req.wdata[15:8];
        end
    end
    io_off_a: assert property (!shadow_q[SBCC_IO_EN_BIT] |=>
        !gate.io_respond) else $error("io response while disabled");
    mem_off_a: assert property (!shadow_q[SBCC_MEM_EN_BIT] |=>
        !gate.mem_rd_respond) else $error("memory read while disabled");
    bme_off_a: assert property (!shadow_q[SBCC_BUS_MASTER_BIT] |=>
        !gate.master_en) else $error("mastering while disabled");
    serr_off_a: assert property (!shadow_q[SBCC_SERR_EN_BIT] |=>
        !gate.err_msg_send && !gate.serr_drive)
        else $error("error report while disabled");
    intx_dis_a: assert property (shadow_q[SBCC_INT_DIS_BIT] |=>
        !gate.intx_assert) else $error("intx while disabled");
    rd_answer_a: assert property (cfg_req.req && !cfg_req.we |=>
        cfg_rsp.valid) else $error("read not answered");
    ro_zero_a: assert property (cfg_rsp.valid |->
        (cfg_rsp.rdata & 32'hFEFF_FAB8) == 0) else $error("ro bit set");
    no_snoop_a: assert property (!gate.special_cyc_respond &&
        !gate.palette_snoop) else $error("special or snoop response");
    resp_bme_a: assert property (gate.io_respond ||
        gate.mem_rd_respond |-> gate.master_en) else $error("resp no bme");
    split_ok_a: assert property (reverse_mode && pcix_mode |=>
        gate.split_cpl_en) else $error("split completion blocked");
    mwi_fwd_a: assert property (pcix_mode || !fwd_mwi_req |=>
        !gate.mwi_originate) else $error("mwi originated");
    err_rep_a: assert property (!err_event |=> !gate.err_msg_send &&
        !gate.serr_drive) else $error("error report without cause");
    intx_rel_a: assert property (!intx_pending |=>
        !gate.intx_assert) else $error("intx without source");
    cover property (gate.intx_assert);
    cover property (gate.serr_drive);
    cover property (cfg_rsp.valid && cfg_rsp.rdata[24]);
    cover property (shadow_q[SBCC_INT_DIS_BIT] && intx_pending);
endmodule : sbcc_cmd_properties
`default_nettype wire

//--- verif/tb_secondary_bus_command_control.sv
// self-checking bench for the secondary bus command register
`timescale 1ns/100ps
`default_nettype none
module tb_secondary_bus_command_control;
    import sbcc_pkg::*;
    logic clk = 0, rst_n = 0, pe = 0, rv, px, mw, er, ix;
    sbcc_cfg_req_t rq = '0;
    sbcc_cfg_rsp_t rs;
    sbcc_gate_t    g;
    logic [31:0]   exq[$];
    logic [15:0]   v;
    int            err_total = 0, compares = 0;
    sbcc_cmd u_dut (.clk(clk), .rst_n(rst_n), .cfg_req(rq), .cfg_rsp(rs),
        .reverse_mode(rv), .pcix_mode(px), .fwd_mwi_req(mw),
        .parity_event(pe), .err_event(er), .intx_pending(ix), .gate(g));
    sbcc_far_model u_far (.clk(clk), .rev(rv), .pcx(px), .mwi(mw),
        .err(er), .intx(ix));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task acc(input logic w, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk) #1 rq = '{1'b1, w, SBCC_CMD_OFFSET, b, d};
        @(posedge clk) #1 rq = '0;
    endtask : acc
    task rd(input logic [11:0] a, input logic [31:0] e);
        exq.push_back(e);
        @(posedge clk) #1 rq = '{1'b1, 1'b0, a, 4'hF, 32'h0};
        @(posedge clk) #1 rq = '0;
    endtask : rd
    task pulse;
        @(posedge clk) #1 pe = 1;
        @(posedge clk) #1 pe = 0;
    endtask : pulse
    task tally_and_finish;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // answers are matched oldest first against what the driver queued
    always @(posedge clk) if (rs.valid === 1'b1) begin
        chk("rdata", rs.rdata, exq.pop_front());
    end
    initial begin
        v = 16'($urandom(32'h8E6A));
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        rd(SBCC_CMD_OFFSET, 32'h0);
        acc(1, 4'h3, 32'hFFFF_FFFF);
        rd(SBCC_CMD_OFFSET, 32'h0547);
        repeat (10) begin
            v = 16'($urandom);
            acc(1, 4'h3, {16'h0, v});
            rd(SBCC_CMD_OFFSET, {16'h0, v & SBCC_CMD_WR_MASK});
            chk("gates", 32'({g.io_respond, g.mem_rd_respond,
                g.master_en}), 32'({v[0] & v[2], v[1] & v[2], v[2]}));
        end
        acc(1, 4'h3, 32'h0);
        pulse();
        rd(SBCC_CMD_OFFSET, 32'h0);
        acc(1, 4'h1, 32'h40);
        pulse();
        rd(SBCC_CMD_OFFSET, 32'h0100_0040);
        acc(1, 4'h8, 32'h0100_0000);
        rd(SBCC_CMD_OFFSET, 32'h40);
        rd(12'h048, 32'h0);
        acc(1, 4'h3, 32'hFFFF_FFFF);
        pulse();
        rd(SBCC_CMD_OFFSET, 32'h0100_0547);
        @(posedge clk) #1 rst_n = 0;
        @(posedge clk) #1 rst_n = 1;
        chk("gates_rst", 32'(g), 32'h0);
        rd(SBCC_CMD_OFFSET, 32'h0);
        repeat (3) @(posedge clk);
        chk("queue", 32'(exq.size()), 32'h0);
        tally_and_finish();
    end
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_secondary_bus_command_control
bind sbcc_cmd sbcc_cmd_properties u_props (.clk(clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .reverse_mode(reverse_mode),
    .pcix_mode(pcix_mode), .fwd_mwi_req(fwd_mwi_req), .gate(gate),
    .parity_event(parity_event), .err_event(err_event),
    .intx_pending(intx_pending));
`default_nettype wire
